// >>> bench/sfba_l2_model.sv
// Purpose: L2 stand-in returning one credit per data phase.
// Assumes: Every command is accepted whole.
// Notes: Slow mode returns credit one cycle in four.
`timescale 1ns/1ps
module sfba_l2_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_slow,
  input  wire sfba_pkg::sfba_port_t i_port_a,
  input  wire sfba_pkg::sfba_port_t i_port_b,
  output logic                      o_credit_a,
  output logic                      o_credit_b,
  output logic                      o_idle
);
  import sfba_pkg::*;
  int  pend_a, pend_b, tick;
  wire go   = !i_slow || tick % 4 == 0;
  wire go_a = go && pend_a > 0;
  wire go_b = go && pend_b > 0;
  assign o_idle = pend_a == 0 && pend_b == 0;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_a     <= 0;
      pend_b     <= 0;
      tick       <= 0;
      o_credit_a <= 1'b0;
      o_credit_b <= 1'b0;
    end else begin
      tick       <= tick + 1;
      pend_a     <= pend_a + (i_port_a.v ? 1 + i_port_a.cmd.two_ph : 0) - go_a;
      pend_b     <= pend_b + (i_port_b.v ? 1 + i_port_b.cmd.two_ph : 0) - go_b;
      o_credit_a <= go_a;
      o_credit_b <= go_b;
    end
  end
endmodule

// >>> bench/sfba_monitor.sv
// Purpose: Assertions on the arbiter and data path ports of sfba_top.
// Assumes: Preference starts at zero.
// Notes: Credit use counts issued phases less returns.
`timescale 1ns/1ps
module sfba_monitor (
  input wire logic                      I_CLK_SYS,
  input wire logic                      I_RST_B,
  input wire sfba_pkg::sfba_req_t [1:0] I_CMD,
  input wire logic [1:0][1:0]           O_CMD_TAKEN,
  input wire logic                      I_CREDIT_A,
  input wire logic                      I_CREDIT_B,
  input wire sfba_pkg::sfba_port_t      O_PORT_A,
  input wire sfba_pkg::sfba_port_t      O_PORT_B,
  input wire logic [1:0]                O_REF_TAKEN,
  input wire logic [1:0]                O_VEC_V,
  input wire logic                      O_SAFETY_ERR,
  input wire logic                      O_SAFETY_INJ
);
  import sfba_pkg::*;
  sfba_req_t [1:0] prev;
  logic [3:0]      tk;
  logic            pref;
  logic [4:0]      use_a, use_b;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      prev  <= '0;
      tk    <= 4'h0;
      pref  <= 1'b0;
      use_a <= 5'h00;
      use_b <= 5'h00;
    end else begin
      prev  <= I_CMD;
      tk    <= O_CMD_TAKEN;
      pref  <= pref ^ (O_PORT_A.v | O_PORT_B.v);
      use_a <= use_a + 5'(O_PORT_A.v) + 5'(O_PORT_A.v & O_PORT_A.cmd.two_ph) - 5'(I_CREDIT_A);
      use_b <= use_b + 5'(O_PORT_B.v) + 5'(O_PORT_B.v & O_PORT_B.cmd.two_ph) - 5'(I_CREDIT_B);
    end
  end
  a_taken_split: assert property (
    O_CMD_TAKEN[1] == 2'(O_PORT_A.v & O_PORT_A.strm) + 2'(O_PORT_B.v & O_PORT_B.strm))
    else $error("Taken count wrong.");
  a_credit_a: assert property (use_a <= 5'h08) else $error("Port A over credit.");
  a_credit_b: assert property (use_b <= 5'h08) else $error("Port B over credit.");
  a_oldest_a: assert property (
    O_PORT_A.v && tk == 4'h0 |-> O_PORT_A.cmd == prev[O_PORT_A.strm].c[0])
    else $error("Port A not oldest.");
  a_pref_a: assert property (
    O_PORT_A.v && tk == 4'h0 && prev[pref].v[0] && !prev[pref].c[0].two_ph |->
    O_PORT_A.strm == pref) else $error("Port A skipped preference.");
  a_pref_b: assert property (
    O_PORT_A.v && O_PORT_B.v && tk == 4'h0 && O_PORT_A.strm == pref && prev[!pref].v[0]
    && !prev[!pref].c[0].two_ph |-> O_PORT_B.strm == !pref)
    else $error("Port B skipped preference.");
  a_ref_vec: assert property ((O_REF_TAKEN & ~O_VEC_V) == 2'b00)
    else $error("Retire without vector.");
  a_inj_err: assert property (O_SAFETY_INJ |-> O_SAFETY_ERR)
    else $error("Injected flag without fault.");
  a_err_access: assert property (O_SAFETY_ERR |-> $past(O_REF_TAKEN) != 2'b00)
    else $error("Parity fault outside a read.");
endmodule
bind sfba_top sfba_monitor u_mon (.I_CLK_SYS, .I_RST_B, .I_CMD, .O_CMD_TAKEN, .I_CREDIT_A,
  .I_CREDIT_B, .O_PORT_A, .O_PORT_B, .O_REF_TAKEN, .O_VEC_V, .O_SAFETY_ERR, .O_SAFETY_INJ);

// >>> bench/sfba_top_tb.sv
// Purpose: Self-checking bench for sfba_top.
// Assumes: Format registers stay at reset, so vectors are plain rotations.
// Notes: Random traffic comes from a fixed seed.
`timescale 1ns/1ps
`include "sfba_cfg.svh"
module sfba_top_tb;
  import sfba_pkg::*;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic [5:0]       av_addr = '0;
  logic             av_rd = 1'b0;
  logic             av_wr = 1'b0;
  logic [31:0]      av_wd = '0;
  logic [31:0]      av_rdata;
  logic             av_wait;
  logic [1:0]       priv = '0;
  sfba_req_t [1:0]  cmd = '0;
  logic [1:0][1:0]  taken;
  logic             cred_a, cred_b, watch, s_err, s_inj, idle;
  sfba_port_t       port_a, port_b;
  sfba_fill_t       fill = '0;
  logic [1:0]       alloc_v = '0;
  logic [1:0][4:0]  alloc_sl = '0;
  sfba_ref_t [1:0]  refs = '0;
  logic [1:0]       ref_tk, vec_v;
  sfba_line_t [1:0] vec;
  logic             slow = 1'b0;
  sfba_cmd_t        q[2][$];
  int               fails = 0;
  int               cmp_count = 0;
  int               cyc = 0;
  sfba_top DUT (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(av_addr), .I_AVS_READ(av_rd),
    .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd), .I_AVS_BYTEENABLE(4'hf),
    .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(av_wait), .I_BIG_ENDIAN(1'b0),
    .I_PRIV(priv), .I_VIRTUAL_MACHINE_CRITERION(16'h0000), .I_DEBUG_CONTEXT_CRITERION(16'h0000), .I_CMD(cmd), .O_CMD_TAKEN(taken),
    .I_CREDIT_A(cred_a), .I_CREDIT_B(cred_b), .O_PORT_A(port_a), .O_PORT_B(port_b),
    .I_FILL(fill), .I_ALLOC_V(alloc_v), .I_ALLOC_SLOT(alloc_sl), .I_REF(refs),
    .O_REF_TAKEN(ref_tk), .O_VEC(vec), .O_VEC_V(vec_v), .I_VEC_TAKE(2'b11),
    .O_WATCH_TRIG(watch), .O_SAFETY_ERR(s_err), .O_SAFETY_INJ(s_inj));
  sfba_l2_model u_l2 (.i_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_port_a(port_a),
    .i_port_b(port_b), .o_credit_a(cred_a), .o_credit_b(cred_b), .o_idle(idle));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [511:0] exp, input logic [511:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n = 0;
    @(posedge clk);
    av_addr <= a;
    av_wd   <= d;
    av_wr   <= wr;
    av_rd   <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (av_wait !== 1'b0 && n < 50);
    r = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (n >= 50) fails++;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check("register", 512'(exp), 512'(r));
  endtask
  task automatic alloc(input logic s, input logic [4:0] sl);
    @(posedge clk);
    alloc_v[s]  <= 1'b1;
    alloc_sl[s] <= sl;
    @(posedge clk);
    alloc_v <= 2'b00;
  endtask
  task automatic put(input logic s, input logic [4:0] sl, input sfba_line_t d);
    @(posedge clk);
    fill <= '{v: 1'b1, strm: s, slot: sl, data: d};
    @(posedge clk);
    fill.v <= 1'b0;
  endtask
  function automatic sfba_line_t rnd_line();
    for (int i = 0; i < 16; i++) rnd_line[i*32 +: 32] = $urandom;
  endfunction
  function automatic sfba_line_t rotated(input sfba_line_t lo, hi, input logic [5:0] r);
    return 512'({hi, lo} >> (8 * r));
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 9000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    logic [4:0] lo, hi;
    logic [5:0] rot;
    logic       s, npref;
    int         n, gen;
    int         k[2];
    sfba_line_t dlo, dhi;
    sfba_port_t pt;
    void'($urandom(84318));
    npref = 1'b0;
    gen = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`SFBA_OFS_STAT, 32'h0000_0880);
    rd_chk(6'h3c, 32'h0000_0000);
    wr(`SFBA_OFS_CTRL, 32'hffff_ffe1);
    rd_chk(`SFBA_OFS_CTRL, 32'h0000_0001);
    repeat (700) begin
      @(posedge clk);
      k = '{0, 0};
      for (int p = 0; p < 2; p++) begin
        pt = p ? port_b : port_a;
        if (pt.v === 1'b1) begin
          check("issued command", 512'(q[pt.strm][k[pt.strm]]), 512'(pt.cmd));
          check("interest tag", 512'(!pt.strm), 512'(pt.cint));
          k[pt.strm]++;
        end
      end
      check("watch trigger", 512'(0), 512'(watch));
      npref ^= port_a.v | port_b.v;
      for (int j = 0; j < 2; j++) begin
        check("taken count", 512'(k[j]), 512'(taken[j]));
        repeat (taken[j]) void'(q[j].pop_front());
        repeat ((gen < 400) ? $urandom_range(2) : 0) begin
          q[j].push_back('{addr: 40'($urandom), slot: 5'($urandom), two_ph: 1'($urandom)});
          gen++;
        end
        cmd[j].v    <= {q[j].size() > 1, q[j].size() > 0};
        cmd[j].c[0] <= q[j][0];
        cmd[j].c[1] <= q[j][1];
      end
      slow <= $urandom_range(3) == 0;
      priv <= 2'($urandom);
    end
    check("queues drained", 512'(1), 512'(q[0].size() + q[1].size() == 0));
    n = 0;
    while (idle !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    rd_chk(`SFBA_OFS_STAT, {31'h0000_0440, npref});
    for (int i = 0; i < 6; i++) begin
      s   = i[0];
      lo  = (i == 5) ? 5'h1f : 5'(i * 7);
      hi  = lo + 5'h01;
      rot = (i == 2) ? 6'h3f : 6'($urandom);
      dlo = rnd_line();
      dhi = rnd_line();
      alloc(s, lo);
      alloc(s, hi);
      if (i == 3) wr(`SFBA_OFS_CTRL, 32'h0000_0005);
      put(s, lo, dlo);
      if (i == 3) wr(`SFBA_OFS_CTRL, 32'h0000_0001);
      refs[s] <= '{v: 1'b1, lo: lo, hi: hi, rot: rot};
      repeat (4) begin
        @(posedge clk);
        check("early retire", 512'(0), 512'(ref_tk[s]));
      end
      put(s, hi, dhi);
      n = 0;
      while (ref_tk[s] !== 1'b1 && n < 40) begin
        @(posedge clk);
        n++;
      end
      refs[s].v <= 1'b0;
      check("vector", rotated(dlo, dhi, rot), vec[s]);
      @(posedge clk);
      check("parity fault", 512'(i == 3), 512'(s_err));
      check("injected fault", 512'(i == 3), 512'(s_inj));
    end
    rd_chk(`SFBA_OFS_STAT, {31'h0000_1c40, npref});
    wr(`SFBA_OFS_STAT, 32'h0000_3000);
    rd_chk(`SFBA_OFS_STAT, {31'h0000_0440, npref});
    give_verdict();
  end
endmodule

// >>> inc/sfba_cfg.svh
// Purpose: Constants for the stream fetch back end and its arbiter.
// Assumes: One core clock; byte offsets on Avalon-MM.
// Notes: Types live in sfba_pkg; this header holds only macros.
// What this block does
// - Each stream owns 32 slots of 64 bytes.
// - Formatting moves the next element to byte lane 0.
// - Formatting reverses, swaps endian, swaps halves, promotes, decimates, duplicates, masks.
// - Byte order follows processor mode; alignment and reversal come from stream parameters.
// - Results wait in small holding registers for full rate.
// - Two shared L2 ports, each 512 bits per cycle.
// - Each L2 port accepts at most one command per cycle, from either stream.
// - Streams offer two commands per cycle, each up to two data phases.
// - Port arbiters examine both streams' two oldest unsent commands and credits.
// - One preference bit decides which stream wins at each port.
// - A port issues only with credit for every data phase of its command, and never without credit.
// - A port takes its preferred stream first, else the other stream.
// - Any issue on either port inverts the preference for the next cycle.
// - Transposed mode rotates coarsely to reassemble data column-wise.
// - Enabled masked watch criteria matching a request raise command interest.
// - A watch match returns a triggered pulse to the hardware watch unit.
// - Streams opened with command interest tag every address they send.
// - One parity bit per 32 data bits, checked on read.
// - Parity faults go to the safety controller, injected or functional.
// - A reference retires only with its data ready and holding room free.
`ifndef SFBA_CFG_SVH
`define SFBA_CFG_SVH
`define SFBA_SLOTS     32
`define SFBA_SLOT_W    5
`define SFBA_BYTES     64
`define SFBA_BYTE_W    8
`define SFBA_LINE_W    512
`define SFBA_WORD_W    32
`define SFBA_PAR_W     16
`define SFBA_PA_W      40
`define SFBA_CRED_MAX  4'h8
`define SFBA_OFS_CTRL  6'h00
`define SFBA_OFS_FMT0  6'h04
`define SFBA_OFS_FMT1  6'h08
`define SFBA_OFS_WCTL  6'h0c
`define SFBA_OFS_WVMID 6'h10
`define SFBA_OFS_WDCTX 6'h14
`define SFBA_OFS_WADDR 6'h18
`define SFBA_OFS_WAMSK 6'h1c
`define SFBA_OFS_STAT  6'h20
`define SFBA_MSK_CTRL  32'h0000_001f
`define SFBA_MSK_FMT   32'h0000_ffff
`define SFBA_MSK_WCTL  32'h0000_00ff
`define SFBA_RST_REG   32'h0000_0000
`endif

// >>> inc/sfba_pkg.sv
// Purpose: Types shared by the stream fetch back end modules.
// Assumes: sfba_cfg.svh supplies the widths.
// Notes: Index 0 of a request pair is the oldest unsent command.
`include "sfba_cfg.svh"
package sfba_pkg;
  typedef logic [`SFBA_LINE_W-1:0] sfba_line_t;
  typedef struct packed {
    logic [`SFBA_PA_W-1:0]   addr;
    logic [`SFBA_SLOT_W-1:0] slot;
    logic                    two_ph;
  } sfba_cmd_t;
  typedef struct packed {
    logic [1:0]      v;
    sfba_cmd_t [1:0] c;
  } sfba_req_t;
  typedef struct packed {
    logic      v;
    logic      strm;
    logic      cint;
    sfba_cmd_t cmd;
  } sfba_port_t;
  typedef struct packed {
    logic                    v;
    logic                    strm;
    logic [`SFBA_SLOT_W-1:0] slot;
    sfba_line_t              data;
  } sfba_fill_t;
  typedef struct packed {
    logic                    v;
    logic [`SFBA_SLOT_W-1:0] lo;
    logic [`SFBA_SLOT_W-1:0] hi;
    logic [5:0]              rot;
  } sfba_ref_t;
  typedef struct packed {
    logic [15:0] rsv;
    logic [6:0]  vlen;
    logic        grp;
    logic        dup;
    logic        dec;
    logic        sgn;
    logic        prom;
    logic        swap;
    logic        back;
    logic [1:0]  esz;
  } sfba_fmt_t;
  typedef struct packed {
    logic [26:0] rsv;
    logic [1:0]  tr;
    logic        inj;
    logic [1:0]  ci;
  } sfba_ctrl_t;
  typedef struct packed {
    logic [23:0] rsv;
    logic [1:0]  pmsk;
    logic [1:0]  pval;
    logic        en_addr;
    logic        en_dctx;
    logic        en_virtual_machine_criterion;
    logic        en_priv;
  } sfba_wctl_t;
  typedef struct packed {
    logic [17:0] rsv;
    logic        pinj;
    logic        perr;
    logic [3:0]  cred_b;
    logic [3:0]  cred_a;
    logic [2:0]  rsv2;
    logic        pref;
  } sfba_stat_t;
  typedef enum logic [1:0] {
    SFBA_HOLD_EMPTY = 2'b00,
    SFBA_HOLD_ONE   = 2'b01,
    SFBA_HOLD_FULL  = 2'b10
  } sfba_hold_t;
endpackage

// >>> rtl/sfba_format.sv
`timescale 1ns/1ps
// Purpose: Data formatting network for one stream.
// Assumes: Group length is a power of two; zero length means no masking.
// Notes: Purely combinational; the caller registers the result.
`include "sfba_cfg.svh"
module sfba_format (
  input  wire sfba_pkg::sfba_line_t i_lo,
  input  wire sfba_pkg::sfba_line_t i_hi,
  input  wire logic [5:0]           i_rot,
  input  wire sfba_pkg::sfba_fmt_t  i_fmt,
  input  wire logic                 i_big,
  input  wire logic                 i_tr,
  output sfba_pkg::sfba_line_t      o_vec
);
  import sfba_pkg::*;
  logic [2*`SFBA_LINE_W-1:0]               cat;
  logic [`SFBA_BYTES-1:0][`SFBA_BYTE_W-1:0] a, b, c, d;

  always_comb begin
    int sz, sh, osh, e, o, s, vl;
    sz = 1 << i_fmt.esz;
    osh = int'(i_fmt.esz) + int'(i_fmt.prom);
    vl = int'(i_fmt.vlen);
    e = 0;
    o = 0;
    s = 0;
    // Coarse rotation steps in whole elements for transposed access.
    sh = i_tr ? ((int'(i_rot) << i_fmt.esz) & (`SFBA_BYTES - 1)) : int'(i_rot);
    cat = {i_hi, i_lo} >> (sh * `SFBA_BYTE_W);
    a = cat[`SFBA_LINE_W-1:0];
    for (int i = 0; i < `SFBA_BYTES; i++) begin
      e = i >> i_fmt.esz;
      o = i & (sz - 1);
      if (i_fmt.back) e = (`SFBA_BYTES >> i_fmt.esz) - 1 - e;
      if (i_big) o = sz - 1 - o;
      if (i_fmt.swap && sz > 1) o = o ^ (sz >> 1);
      b[i] = a[(e << i_fmt.esz) | o];
    end
    for (int i = 0; i < `SFBA_BYTES; i++) begin
      e = i >> osh;
      o = i & ((1 << osh) - 1);
      if (i_fmt.dec) e = e << 1;
      if (i_fmt.dup) e = e >> 1;
      s = (e << i_fmt.esz) | (o & (sz - 1));
      if (s >= `SFBA_BYTES) begin
        c[i] = 8'h00;
      end else if (o < sz) begin
        c[i] = b[s];
      end else begin
        c[i] = (i_fmt.sgn && b[s | (sz - 1)][`SFBA_BYTE_W-1]) ? 8'hff : 8'h00;
      end
    end
    for (int i = 0; i < `SFBA_BYTES; i++) begin
      if (vl == 0 || i < vl) begin
        d[i] = c[i];
      end else begin
        d[i] = i_fmt.grp ? c[i & (vl - 1)] : 8'h00;
      end
    end
    o_vec = d;
  end
endmodule

// >>> rtl/sfba_top.sv
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
// Purpose: Slot store, formatting, holding registers and dual L2 port arbiter.
// Assumes: Command and reference sources shift one cycle after a taken pulse.
// Notes: Registers sit on an Avalon-MM slave with one wait state.
`include "sfba_cfg.svh"
module sfba_top (
  input  wire logic                    I_CLK_SYS,
  input  wire logic                    I_RST_B,
  input  wire logic [5:0]              I_AVS_ADDRESS,
  input  wire logic                    I_AVS_READ,
  input  wire logic                    I_AVS_WRITE,
  input  wire logic [31:0]             I_AVS_WRITEDATA,
  input  wire logic [3:0]              I_AVS_BYTEENABLE,
  output logic [31:0]                  O_AVS_READDATA,
  output logic                         O_AVS_WAITREQUEST,
  input  wire logic                    I_BIG_ENDIAN,
  input  wire logic [1:0]              I_PRIV,
  input  wire logic [15:0]             I_VIRTUAL_MACHINE_CRITERION,
  input  wire logic [15:0]             I_DEBUG_CONTEXT_CRITERION,
  input  wire sfba_pkg::sfba_req_t [1:0] I_CMD,
  output logic [1:0][1:0]              O_CMD_TAKEN,
  input  wire logic                    I_CREDIT_A,
  input  wire logic                    I_CREDIT_B,
  output sfba_pkg::sfba_port_t         O_PORT_A,
  output sfba_pkg::sfba_port_t         O_PORT_B,
  input  wire sfba_pkg::sfba_fill_t    I_FILL,
  input  wire logic [1:0]              I_ALLOC_V,
  input  wire logic [1:0][4:0]         I_ALLOC_SLOT,
  input  wire sfba_pkg::sfba_ref_t [1:0] I_REF,
  output logic [1:0]                   O_REF_TAKEN,
  output sfba_pkg::sfba_line_t [1:0]   O_VEC,
  output logic [1:0]                   O_VEC_V,
  input  wire logic [1:0]              I_VEC_TAKE,
  output logic                         O_WATCH_TRIG,
  output logic                         O_SAFETY_ERR,
  output logic                         O_SAFETY_INJ
);
  import sfba_pkg::*;

  logic       rst_m_b;
  logic       rst_b;
  sfba_ctrl_t ctrl;
  sfba_fmt_t  [1:0] fmt;
  sfba_wctl_t wctl;
  logic [31:0] wvmid;
  logic [31:0] wdctx;
  logic [31:0] waddr;
  logic [31:0] wamsk;
  sfba_stat_t stat;
  logic        pref;
  logic [3:0]  cred_a;
  logic [3:0]  cred_b;
  logic        perr;
  logic        pinj;
  logic        req;
  logic        wr;
  logic [31:0] rdata;
  sfba_stat_t  wst;

  sfba_line_t mem [2][`SFBA_SLOTS];
  logic [`SFBA_PAR_W-1:0] par [2][`SFBA_SLOTS];
  logic                   inj [2][`SFBA_SLOTS];
  logic [1:0][`SFBA_SLOTS-1:0] rdy;

  sfba_cmd_t vc [2][2];
  logic      vv [2][2];
  logic      a_v;
  logic      a_s;
  logic      b_v;
  logic      b_s;
  logic      b_i;
  logic [1:0] rtk;
  logic [1:0] err;
  logic [1:0] erj;

  function automatic logic [31:0] bmerge(input logic [31:0] old);
    for (int i = 0; i < 4; i++) begin
      bmerge[i*`SFBA_BYTE_W +: `SFBA_BYTE_W] = I_AVS_BYTEENABLE[i]
        ? I_AVS_WRITEDATA[i*`SFBA_BYTE_W +: `SFBA_BYTE_W]
        : old[i*`SFBA_BYTE_W +: `SFBA_BYTE_W];
    end
  endfunction

  function automatic logic [`SFBA_PAR_W-1:0] parity(input sfba_line_t d);
    for (int i = 0; i < `SFBA_PAR_W; i++) begin
      parity[i] = ^d[i*`SFBA_WORD_W +: `SFBA_WORD_W];
    end
  endfunction

  // Any enabled criterion that mismatches blocks the match.
  function automatic logic whit(input sfba_cmd_t c);
    logic m;
    m = wctl.en_priv | wctl.en_virtual_machine_criterion | wctl.en_dctx | wctl.en_addr;
    if (wctl.en_priv && ((I_PRIV ^ wctl.pval) & wctl.pmsk) != 2'h0) m = 1'b0;
    if (wctl.en_virtual_machine_criterion && ((I_VIRTUAL_MACHINE_CRITERION ^ wvmid[15:0]) & wvmid[31:16]) != 16'h0) m = 1'b0;
    if (wctl.en_dctx && ((I_DEBUG_CONTEXT_CRITERION ^ wdctx[15:0]) & wdctx[31:16]) != 16'h0) m = 1'b0;
    if (wctl.en_addr && ((c.addr[31:0] ^ waddr) & wamsk) != 32'h0) m = 1'b0;
    return m;
  endfunction

  function automatic logic fits(input logic [3:0] cr, input sfba_cmd_t c);
    return cr > {3'h0, c.two_ph};
  endfunction

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_m_b <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_m_b <= 1'b1;
      rst_b <= rst_m_b;
    end
  end

  // One wait state on every access.
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign wr = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
  assign wst = I_AVS_WRITEDATA;

  always_comb begin
    stat = '0;
    stat.pref = pref;
    stat.cred_a = cred_a;
    stat.cred_b = cred_b;
    stat.perr = perr;
    stat.pinj = pinj;
    case (I_AVS_ADDRESS)
      `SFBA_OFS_CTRL: rdata = ctrl;
      `SFBA_OFS_FMT0: rdata = fmt[0];
      `SFBA_OFS_FMT1: rdata = fmt[1];
      `SFBA_OFS_WCTL: rdata = wctl;
      `SFBA_OFS_WVMID: rdata = wvmid;
      `SFBA_OFS_WDCTX: rdata = wdctx;
      `SFBA_OFS_WADDR: rdata = waddr;
      `SFBA_OFS_WAMSK: rdata = wamsk;
      `SFBA_OFS_STAT: rdata = stat;
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= `SFBA_RST_REG;
    end else begin
      O_AVS_WAITREQUEST <= ~(req & O_AVS_WAITREQUEST);
      if (req && O_AVS_WAITREQUEST) begin
        O_AVS_READDATA <= rdata;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `SFBA_RST_REG;
      fmt <= {`SFBA_RST_REG, `SFBA_RST_REG};
      wctl <= `SFBA_RST_REG;
      wvmid <= `SFBA_RST_REG;
      wdctx <= `SFBA_RST_REG;
      waddr <= `SFBA_RST_REG;
      wamsk <= `SFBA_RST_REG;
    end else if (wr) begin
      case (I_AVS_ADDRESS)
        `SFBA_OFS_CTRL: ctrl <= bmerge(ctrl) & `SFBA_MSK_CTRL;
        `SFBA_OFS_FMT0: fmt[0] <= bmerge(fmt[0]) & `SFBA_MSK_FMT;
        `SFBA_OFS_FMT1: fmt[1] <= bmerge(fmt[1]) & `SFBA_MSK_FMT;
        `SFBA_OFS_WCTL: wctl <= bmerge(wctl) & `SFBA_MSK_WCTL;
        `SFBA_OFS_WVMID: wvmid <= bmerge(wvmid);
        `SFBA_OFS_WDCTX: wdctx <= bmerge(wdctx);
        `SFBA_OFS_WADDR: waddr <= bmerge(waddr);
        `SFBA_OFS_WAMSK: wamsk <= bmerge(wamsk);
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Injection flips a stored parity bit so the next read faults.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_FILL.v) begin
      mem[I_FILL.strm][I_FILL.slot] <= I_FILL.data;
      par[I_FILL.strm][I_FILL.slot] <= parity(I_FILL.data) ^ {15'h0, ctrl.inj};
      inj[I_FILL.strm][I_FILL.slot] <= ctrl.inj;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      rdy <= '0;
    end else begin
      for (int s = 0; s < 2; s++) begin
        if (I_ALLOC_V[s]) rdy[s][I_ALLOC_SLOT[s]] <= 1'b0;
      end
      if (I_FILL.v) rdy[I_FILL.strm][I_FILL.slot] <= 1'b1;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_strm
    sfba_line_t lo;
    sfba_line_t hi;
    sfba_line_t fv;
    sfba_line_t h1;
    sfba_hold_t hs;
    sfba_hold_t next_hs;
    logic       ok;
    logic       pop;

    assign lo = mem[s][I_REF[s].lo];
    assign hi = mem[s][I_REF[s].hi];
    assign ok = I_REF[s].v & ~rtk[s] & rdy[s][I_REF[s].lo] & rdy[s][I_REF[s].hi]
                & (hs != SFBA_HOLD_FULL);
    assign pop = I_VEC_TAKE[s] & O_VEC_V[s];

    sfba_format u_fmt (
      .i_lo  (lo),
      .i_hi  (hi),
      .i_rot (I_REF[s].rot),
      .i_fmt (fmt[s]),
      .i_big (I_BIG_ENDIAN),
      .i_tr  (ctrl.tr[s]),
      .o_vec (fv)
    );

    always_comb begin
      next_hs = hs;
      case (hs)
        SFBA_HOLD_EMPTY: if (ok) next_hs = SFBA_HOLD_ONE;
        SFBA_HOLD_ONE: begin
          if (ok && !pop) next_hs = SFBA_HOLD_FULL;
          else if (!ok && pop) next_hs = SFBA_HOLD_EMPTY;
        end
        SFBA_HOLD_FULL: if (pop) next_hs = SFBA_HOLD_ONE;
        default: next_hs = SFBA_HOLD_EMPTY;
      endcase
    end

    // Two-entry elastic holding registers feeding the processor.
    always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
      if (!rst_b) begin
        hs <= SFBA_HOLD_EMPTY;
        O_VEC_V[s] <= 1'b0;
        O_VEC[s] <= '0;
        h1 <= '0;
      end else begin
        hs <= next_hs;
        O_VEC_V[s] <= next_hs != SFBA_HOLD_EMPTY;
        if (hs == SFBA_HOLD_FULL && pop) O_VEC[s] <= h1;
        else if (ok && (hs == SFBA_HOLD_EMPTY || pop)) O_VEC[s] <= fv;
        if (ok && hs == SFBA_HOLD_ONE && !pop) h1 <= fv;
      end
    end

    always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
      if (!rst_b) begin
        rtk[s] <= 1'b0;
        err[s] <= 1'b0;
        erj[s] <= 1'b0;
      end else begin
        rtk[s] <= ok;
        err[s] <= ok & ((parity(lo) != par[s][I_REF[s].lo])
                        | (parity(hi) != par[s][I_REF[s].hi]));
        erj[s] <= ok & (inj[s][I_REF[s].lo] | inj[s][I_REF[s].hi]);
      end
    end
  end

  assign O_REF_TAKEN = rtk;

  // Commands still visible after the source's pending shift.
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      vc[s][0] = O_CMD_TAKEN[s] == 2'h0 ? I_CMD[s].c[0] : I_CMD[s].c[1];
      vc[s][1] = I_CMD[s].c[1];
      vv[s][0] = O_CMD_TAKEN[s] == 2'h0 ? I_CMD[s].v[0]
               : (O_CMD_TAKEN[s] == 2'h1 && I_CMD[s].v[1]);
      vv[s][1] = O_CMD_TAKEN[s] == 2'h0 && I_CMD[s].v[0] && I_CMD[s].v[1];
    end
  end

  // Port A prefers stream pref, port B the other; B skips what A took.
  always_comb begin
    logic ip;
    logic io;
    a_s = vv[pref][0] ? pref : ~pref;
    a_v = vv[a_s][0] && fits(cred_a, vc[a_s][0]);
    ip = a_v && (a_s == ~pref);
    io = a_v && (a_s == pref);
    if (vv[~pref][ip]) begin
      b_s = ~pref;
      b_i = ip;
    end else begin
      b_s = pref;
      b_i = io;
    end
    b_v = vv[b_s][b_i] && fits(cred_b, vc[b_s][b_i]);
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      O_PORT_A <= '0;
      O_PORT_B <= '0;
      O_CMD_TAKEN <= '0;
      O_WATCH_TRIG <= 1'b0;
    end else begin
      O_PORT_A.v <= a_v;
      O_PORT_A.strm <= a_s;
      O_PORT_A.cmd <= vc[a_s][0];
      O_PORT_A.cint <= ctrl.ci[a_s] | whit(vc[a_s][0]);
      O_PORT_B.v <= b_v;
      O_PORT_B.strm <= b_s;
      O_PORT_B.cmd <= vc[b_s][b_i];
      O_PORT_B.cint <= ctrl.ci[b_s] | whit(vc[b_s][b_i]);
      for (int s = 0; s < 2; s++) begin
        O_CMD_TAKEN[s] <= {1'b0, a_v && a_s == s[0]} + {1'b0, b_v && b_s == s[0]};
      end
      O_WATCH_TRIG <= (a_v & whit(vc[a_s][0])) | (b_v & whit(vc[b_s][b_i]));
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      pref <= 1'b0;
      cred_a <= `SFBA_CRED_MAX;
      cred_b <= `SFBA_CRED_MAX;
    end else begin
      if (a_v || b_v) pref <= ~pref;
      cred_a <= cred_a - (a_v ? 4'h1 + {3'h0, vc[a_s][0].two_ph} : 4'h0)
                + {3'h0, I_CREDIT_A};
      cred_b <= cred_b - (b_v ? 4'h1 + {3'h0, vc[b_s][b_i].two_ph} : 4'h0)
                + {3'h0, I_CREDIT_B};
    end
  end

  // Sticky bits clear on write-one; a new fault wins.
  always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      O_SAFETY_ERR <= 1'b0;
      O_SAFETY_INJ <= 1'b0;
      perr <= 1'b0;
      pinj <= 1'b0;
    end else begin
      O_SAFETY_ERR <= |err;
      O_SAFETY_INJ <= |(err & erj);
      if (|err) perr <= 1'b1;
      else if (wr && I_AVS_ADDRESS == `SFBA_OFS_STAT && wst.perr) perr <= 1'b0;
      if (|(err & erj)) pinj <= 1'b1;
      else if (wr && I_AVS_ADDRESS == `SFBA_OFS_STAT && wst.pinj) pinj <= 1'b0;
    end
  end
endmodule
